// >>> design/i2c_host_end.sv
/*
  I2C master end: takes one command at a time over AHB-Lite and runs it on the link.
  Assumes zero-wait single word transfers and no clock stretching by the slave.
*/
`timescale 1ns/1ns
`include "sup_params.svh"
module i2c_host_end #(
  parameter int QUARTER = `I2C_QUARTER
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Link
  i2c_link_if.host link
);
  typedef struct packed {
    sup_pkg::host_state_type st;
    logic [7:0] q;
    logic [1:0] ph;
    logic [3:0] bitn;
    logic [1:0] bidx;
    logic [1:0] last;
    logic recv;
    logic [23:0] bytes;
    logic [7:0] rx;
    logic [7:0] rdata;
    logic nack;
    logic busy;
    logic scl_oe;
    logic sda_oe;
    logic a_sel;
    logic a_wr;
    logic [7:0] a_addr;
    logic [31:0] rd;
  } host_reg_type;
  localparam logic [7:0] QEND = 8'(QUARTER - 1);

  host_reg_type r;
  host_reg_type r_nxt;
  logic [1:0] syn;

  pin_sync #(
    .W(2)
  ) u_sync (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .async_in({link.scl, link.sda}),
    .sync_out(syn)
  );

  always_comb begin
    logic go;
    logic tick;
    logic rcv;
    logic [7:0] cur;
    logic [1:0] kind;
    go = 1'b0;
    tick = 1'b0;
    rcv = 1'b0;
    cur = 8'h00;
    kind = 2'h0;
    r_nxt = r;
    //////////////////////////////////////////////////////////////////////////////
    // Bus slave; a launch in this data phase already shows as busy
    go = r.a_sel && r.a_wr && r.a_addr == `HOST_CMD && hwdata[`CMD_GO] && !r.busy;
    kind = hwdata[`CMD_KIND_LO+1:`CMD_KIND_LO];
    r_nxt.a_sel = hsel && hready && htrans[1];
    r_nxt.a_wr = hwrite;
    r_nxt.a_addr = haddr[7:0];
    r_nxt.rd = 32'h00000000;
    if (haddr[7:0] == `HOST_STAT) begin
      r_nxt.rd = {16'h0000, r.rdata, 6'h00, r.nack, r.busy || go};
    end
    if (go) begin
      r_nxt.busy = 1'b1;
      r_nxt.nack = 1'b0;
      r_nxt.st = sup_pkg::h_start;
      r_nxt.q = 8'h00;
      r_nxt.ph = 2'h0;
      r_nxt.bidx = 2'h0;
      r_nxt.bitn = 4'h0;
      r_nxt.recv = kind == `KIND_READ;
      r_nxt.bytes = {hwdata[`CMD_DATA_LO+:8], hwdata[`CMD_PTR_LO+:8],
        `I2C_DEV_ADDR, kind == `KIND_READ}; // R19 R22
      r_nxt.last = (kind == `KIND_WRITE) ? 2'h2 : ((kind == `KIND_POINT) ? 2'h1 : 2'h1); // R20
    end
    //////////////////////////////////////////////////////////////////////////////
    // Link engine, four quarters per bit
    tick = r.q == QEND;
    if (r.st != sup_pkg::h_idle) begin
      r_nxt.q = tick ? 8'h00 : r.q + 1'b1;
    end
    cur = r.bytes[r.bidx*8+:8];
    rcv = r.recv && r.bidx == 2'h1;
    if (tick) begin
      r_nxt.ph = r.ph + 1'b1;
      unique case (r.st)
        sup_pkg::h_idle: r_nxt.ph = 2'h0;
        sup_pkg::h_start: begin
          if (r.ph == 2'h2) r_nxt.sda_oe = 1'b1;
          if (r.ph == 2'h3) begin
            r_nxt.scl_oe = 1'b1;
            r_nxt.st = sup_pkg::h_bit;
          end
        end
        sup_pkg::h_bit: begin
          unique case (r.ph)
            2'h0: begin
              r_nxt.sda_oe = 1'b0;
              if (r.bitn != `I2C_ACK_BIT && !rcv) begin
                r_nxt.sda_oe = !cur[`I2C_BYTE_MSB - r.bitn[2:0]];
              end
            end
            2'h1: r_nxt.scl_oe = 1'b0; // R18
            2'h2: begin
              if (r.bitn != `I2C_ACK_BIT && rcv) r_nxt.rx = {r.rx[6:0], syn[0]};
              if (r.bitn == `I2C_ACK_BIT && !rcv && syn[0]) r_nxt.nack = 1'b1;
            end
            2'h3: begin
              r_nxt.scl_oe = 1'b1;
              r_nxt.bitn = r.bitn + 1'b1;
              if (r.bitn == `I2C_ACK_BIT) begin
                r_nxt.bitn = 4'h0;
                r_nxt.bidx = r.bidx + 1'b1;
                if (r.nack || r.bidx == r.last) r_nxt.st = sup_pkg::h_stop;
              end
            end
          endcase
        end
        sup_pkg::h_stop: begin
          if (r.ph == 2'h0) r_nxt.sda_oe = 1'b1;
          if (r.ph == 2'h1) r_nxt.scl_oe = 1'b0;
          if (r.ph == 2'h2) r_nxt.sda_oe = 1'b0;
          if (r.ph == 2'h3) begin
            r_nxt.st = sup_pkg::h_idle;
            r_nxt.busy = 1'b0;
            r_nxt.rdata = r.rx;
          end
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      r <= '0;
      r.st <= sup_pkg::h_idle;
    end else begin
      r <= r_nxt;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = r.rd;
  assign link.scl_o = 1'b0;
  assign link.scl_oe = r.scl_oe;
  assign link.sda_m_o = 1'b0;
  assign link.sda_m_oe = r.sda_oe;
endmodule

// >>> design/i2c_link_if.sv
/*
  Two-wire link between the master end and the device end.
  Both wires are open drain; the pull-up is modelled by the level equations.
*/
`timescale 1ns/1ns
interface i2c_link_if;
  logic scl_o;
  logic scl_oe;
  logic sda_m_o;
  logic sda_m_oe;
  logic sda_d_o;
  logic sda_d_oe;
  logic scl;
  logic sda;
  // A driver only ever pulls low; released wires float high
  assign scl = !(scl_oe && !scl_o);
  assign sda = !((sda_m_oe && !sda_m_o) || (sda_d_oe && !sda_d_o));
  modport dev (input scl, input sda, output sda_d_o, output sda_d_oe);
  modport host (input scl, input sda, output scl_o, output scl_oe, output sda_m_o,
    output sda_m_oe);
endinterface

// >>> design/pin_sync.sv
/*
  Two flip-flop synchroniser for a bundle of asynchronous levels.
  Assumes each bit is an independent level; no word coherence is given.
*/
`timescale 1ns/1ns
module pin_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Levels
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_type;
  sync_type r;
  sync_type r_nxt;

  always_comb begin
    r_nxt = r;
    r_nxt.s1 = async_in;
    r_nxt.s2 = r.s1;
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      r <= '0;
    end else begin
      r <= r_nxt;
    end
  end

  assign sync_out = r.s2;
endmodule

// >>> design/sup_device.sv
/*
  Supervisor device end: power-good qualification, thermal reaction, control bits,
  interrupt flags on an open-drain pin, and an I2C slave with auto-increment.
  Assumes comparator, converter and timebase inputs are asynchronous levels and the
  I2C master runs well below sys_clk / 8.
*/
`timescale 1ns/1ns
`include "sup_params.svh"

// Overview of operation
// R1: Power good after 3.3 ms inside tight window
// R2: Clear power good after one switching cycle outside
// R3: Pin shows power good only when display selected
// R4: Pin held set during startup until qualified
// R5: Good window mask suppresses power good action
// R6: Thermal trip forces gates off, flags interrupt
// R7: Bulk switch pulled low at 0, up at 1
// R8: Auxiliary pull-down on at 1, off at reset
// R9: Converter result in low seven bits
// R10: Two-bit select routes one of four inputs
// R11: One code step is 20 mV at mux
// R12: Status change sets matching source bit
// R13: Masked source never raises interrupt pin
// R14: Open-drain pin released high on request
// R15: Host latches sources by setting mask bits
// R16: Seven interrupt sources as listed
// R17: Slave responds at address 77h
// R18: Slave only, 7-bit addressing, master clocked
// R19: Address first, low bit selects read
// R20: Write loads pointer, then data auto-increments
// R21: Read starts at pointer, auto-increments
// R22: Master sets pointer by write before reading
module sup_device #(
  parameter int PG_QUAL_CYCLES = `PG_QUAL_CYCLES
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Link
  i2c_link_if.dev link,
  // Analog monitor levels
  input wire logic in_tight_window,
  input wire logic out_wide_window,
  input wire logic switch_cycle_tick,
  input wire logic thermal_trip,
  input wire logic enable_low,
  input wire logic excess_output_flag,
  input wire logic internal_overcurrent_flag,
  input wire logic overcurrent_indicator_pin,
  input wire logic negative_step_flag,
  // Converter
  input wire logic [`ADC_BITS-1:0] adc_code,
  output logic [1:0] adc_select,
  // Drives
  output logic gate_drive_off,
  output logic bulk_cap_switch,
  output logic aux_driver_o,
  output logic aux_driver_oe,
  output logic irq_out_pin_o,
  output logic irq_out_pin_oe,
  output logic output_in_window
);
  localparam int SYNC_W = `ADC_BITS + 11;
  localparam logic [`PG_CNT_W-1:0] QUAL = PG_QUAL_CYCLES[`PG_CNT_W-1:0];

  sup_pkg::dev_reg_type r;
  sup_pkg::dev_reg_type r_nxt;
  logic [SYNC_W-1:0] raw;
  logic [SYNC_W-1:0] syn;
  logic scl_s;
  logic sda_s;
  logic tight_s;
  logic wide_s;
  logic tick_s;
  logic [`NUM_SRC-1:0] lvl;
  logic [`ADC_BITS-1:0] adc_s;

  //////////////////////////////////////////////////////////////////////////////////
  // Every outside level passes two flops before use
  assign raw = {adc_code, in_tight_window, out_wide_window, switch_cycle_tick,
    negative_step_flag, overcurrent_indicator_pin, internal_overcurrent_flag,
    thermal_trip, enable_low, excess_output_flag, link.scl, link.sda};

  pin_sync #(
    .W(SYNC_W)
  ) u_sync (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .async_in(raw),
    .sync_out(syn)
  );

  assign sda_s = syn[0];
  assign scl_s = syn[1];
  assign tick_s = syn[8];
  assign wide_s = syn[9];
  assign tight_s = syn[10];
  assign adc_s = syn[SYNC_W-1:11];

  //////////////////////////////////////////////////////////////////////////////////
  // Register read view; only the first source register clears on read
  function automatic logic [7:0] reg_read(input sup_pkg::dev_reg_type s);
    logic [7:0] v;
    v = 8'h00;
    unique case (s.ptr)
      `REG_CTRL: v = s.ctrl;
      `REG_MASK: v = s.mask;
      `REG_ADC: v = {1'b0, s.adc}; // R9
      `REG_SRC1: v = s.src1;
      `REG_SRC2: v = {5'h00, s.gate_off, s.started, s.pg};
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  always_comb begin
    logic tick_rise;
    logic scl_rise;
    logic scl_fall;
    logic start_c;
    logic stop_c;
    logic [`NUM_SRC-1:0] msk;
    logic [`NUM_SRC-1:0] rise;
    logic src_clr;
    logic req;
    tick_rise = 1'b0;
    scl_rise = 1'b0;
    scl_fall = 1'b0;
    start_c = 1'b0;
    stop_c = 1'b0;
    msk = '0;
    rise = '0;
    src_clr = 1'b0;
    req = 1'b0;
    r_nxt = r;
    r_nxt.scl_p = scl_s;
    r_nxt.sda_p = sda_s;
    r_nxt.tick_p = tick_s;
    tick_rise = tick_s && !r.tick_p;
    scl_rise = scl_s && !r.scl_p;
    scl_fall = !scl_s && r.scl_p;
    start_c = scl_s && r.scl_p && r.sda_p && !sda_s;
    stop_c = scl_s && r.scl_p && !r.sda_p && sda_s;

    // Qualification timer restarts whenever the tight window is left
    if (!tight_s) begin
      r_nxt.pg_cnt = '0;
    end else if (r.pg_cnt != QUAL) begin
      r_nxt.pg_cnt = r.pg_cnt + 1'b1;
    end
    if (tight_s && r.pg_cnt == QUAL) begin
      r_nxt.pg = 1'b1; // R1
      r_nxt.started = 1'b1; // R4
    end
    // The first tick may end a partial cycle, so the second one clears
    if (!wide_s) begin
      r_nxt.fault_ticks = 2'h0;
    end else if (tick_rise && r.fault_ticks != `PG_FAULT_TICKS) begin
      r_nxt.fault_ticks = r.fault_ticks + 1'b1;
    end
    if (wide_s && r.fault_ticks == `PG_FAULT_TICKS) begin
      r_nxt.pg = 1'b0; // R2
    end

    r_nxt.gate_off = syn[4]; // R6
    r_nxt.adc = adc_s; // R9 R11

    // Sources: ov, shutdown, thermal, pg trip, internal oc, external oc, negative step
    lvl = {syn[7], syn[6], syn[5], r.started && !r.pg, syn[4], syn[3], syn[2]}; // R16
    rise = lvl & ~r.lvl_p;
    r_nxt.lvl_p = lvl;
    msk = r.mask[`NUM_SRC-1:0];
    r_nxt.pend = (r.pend | rise) & ~msk; // R12 R13 R5 R6
    src_clr = 1'b0;

    // Link
    if (start_c) begin
      r_nxt.st = sup_pkg::d_addr;
      r_nxt.bitcnt = 4'h0;
      r_nxt.sda_oe = 1'b0;
    end else if (stop_c) begin
      r_nxt.st = sup_pkg::d_idle;
      r_nxt.sda_oe = 1'b0;
    end else begin
      unique case (r.st)
        sup_pkg::d_idle: r_nxt.sda_oe = 1'b0; // R18
        sup_pkg::d_addr, sup_pkg::d_wr: begin
          if (scl_rise && r.bitcnt != `I2C_ACK_BIT) begin
            r_nxt.shift = {r.shift[6:0], sda_s};
            r_nxt.bitcnt = r.bitcnt + 1'b1;
          end else if (scl_fall && r.bitcnt == `I2C_ACK_BIT) begin
            if (r.st == sup_pkg::d_addr) begin
              if (r.shift[7:1] == `I2C_DEV_ADDR) begin // R17 R19
                r_nxt.sda_oe = 1'b1;
                r_nxt.rw = r.shift[0];
                r_nxt.st = sup_pkg::d_addr_ack;
              end else begin
                r_nxt.st = sup_pkg::d_idle;
              end
            end else begin
              r_nxt.sda_oe = 1'b1;
              r_nxt.st = sup_pkg::d_wr_ack;
              if (r.first) begin
                r_nxt.ptr = r.shift; // R20
              end else begin
                if (r.ptr == `REG_CTRL) begin
                  r_nxt.ctrl = r.shift; // R7 R8 R10
                end
                if (r.ptr == `REG_MASK) begin
                  r_nxt.mask = r.shift; // R13 R15
                end
                r_nxt.ptr = r.ptr + 1'b1; // R20
              end
            end
          end
        end
        sup_pkg::d_addr_ack, sup_pkg::d_wr_ack, sup_pkg::d_rd_ack: begin
          if (scl_rise && r.st == sup_pkg::d_rd_ack && sda_s) begin
            r_nxt.st = sup_pkg::d_idle;
          end else if (scl_fall) begin
            r_nxt.bitcnt = 4'h0;
            r_nxt.sda_oe = 1'b0;
            r_nxt.first = r.st == sup_pkg::d_addr_ack;
            r_nxt.st = sup_pkg::d_wr;
            if (r.st == sup_pkg::d_rd_ack || r.rw) begin
              r_nxt.tx = reg_read(r); // R21
              src_clr = r.ptr == `REG_SRC1;
              r_nxt.ptr = r.ptr + 1'b1; // R21
              r_nxt.sda_oe = !r_nxt.tx[`I2C_BYTE_MSB];
              r_nxt.bitcnt = 4'h1;
              r_nxt.st = sup_pkg::d_rd;
            end
          end
        end
        sup_pkg::d_rd: begin
          if (scl_fall) begin
            if (r.bitcnt == `I2C_ACK_BIT) begin
              r_nxt.sda_oe = 1'b0;
              r_nxt.st = sup_pkg::d_rd_ack;
            end else begin
              r_nxt.sda_oe = !r.tx[`I2C_BYTE_MSB - r.bitcnt[2:0]];
              r_nxt.bitcnt = r.bitcnt + 1'b1;
            end
          end
        end
      endcase
    end

    // Latching a source needs its mask set; a new set beats a read clear
    r_nxt.src1 = (src_clr ? 8'h00 : r.src1) | {1'b0, lvl & msk}; // R12 R15

    // Pin is released (high) on any request
    req = !r.started || (|r.pend) ||
      (r.ctrl[`CTRL_PG_SHOW] && !r.mask[`SRC_PG] && r.pg); // R3 R4 R5 R13
    r_nxt.irq_oe = !req; // R14
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      r <= '0;
      r.scl_p <= 1'b1;
      r.sda_p <= 1'b1;
      r.ctrl <= `CTRL_RESET;
      r.mask <= `MASK_RESET;
      r.st <= sup_pkg::d_idle;
    end else begin
      r <= r_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////////
  // Outputs come straight from state flops; the pin data outputs are tied low
  assign link.sda_d_o = 1'b0;
  assign link.sda_d_oe = r.sda_oe;
  assign adc_select = r.ctrl[`CTRL_ADC_HI:`CTRL_ADC_LO]; // R10
  assign gate_drive_off = r.gate_off; // R6
  assign bulk_cap_switch = r.ctrl[`CTRL_BULK]; // R7
  assign aux_driver_o = 1'b0;
  assign aux_driver_oe = r.ctrl[`CTRL_AUX]; // R8
  assign irq_out_pin_o = 1'b0;
  assign irq_out_pin_oe = r.irq_oe;
  assign output_in_window = r.pg;
endmodule

// >>> design/sup_params.svh
/*
  Shared constants for the supervisor device end and the I2C master end.
  Assumes a 50 MHz sys_clk and inclusion by bare name.
*/
`ifndef SUP_PARAMS_SVH
`define SUP_PARAMS_SVH
// Clock and timing
`define SYS_CLK_KHZ 50000
`define PG_QUAL_TIME_US 3300
`define PG_QUAL_CYCLES ((`PG_QUAL_TIME_US * `SYS_CLK_KHZ + 999) / 1000)
`define PG_CNT_W 18
`define PG_FAULT_TICKS 2'h2
`define I2C_RATE_KHZ 400
`define I2C_QUARTER (`SYS_CLK_KHZ / (4 * `I2C_RATE_KHZ))
// I2C framing
`define I2C_DEV_ADDR 7'h77
`define I2C_ACK_BIT 4'h8
`define I2C_BYTE_MSB 3'h7
// Device register map
`define REG_CTRL 8'h01
`define REG_MASK 8'h09
`define REG_ADC 8'h0a
`define REG_SRC1 8'h14
`define REG_SRC2 8'h15
`define CTRL_RESET 8'h00
`define MASK_RESET 8'h00
// Control fields
`define CTRL_BULK 0
`define CTRL_AUX 1
`define CTRL_ADC_LO 2
`define CTRL_ADC_HI 3
`define CTRL_PG_SHOW 4
// Interrupt source bits
`define NUM_SRC 7
`define SRC_PG 3
// Converter
`define ADC_BITS 7
`define ADC_STEP_UV 20000
`define ADC_DIV_STEP_UV 200000
`define ADC_FULL_MV 25500
// Host register map and command fields
`define HOST_CMD 8'h00
`define HOST_STAT 8'h04
`define CMD_GO 31
`define CMD_KIND_LO 0
`define CMD_PTR_LO 8
`define CMD_DATA_LO 16
`define KIND_WRITE 2'h0
`define KIND_POINT 2'h1
`define KIND_READ 2'h2
`endif

// >>> design/sup_pkg.sv
/*
  Types shared by both ends: state enums and the device end's packed state record.
  Assumes sup_params.svh is on the include path.
*/
`include "sup_params.svh"
package sup_pkg;
  typedef enum logic [2:0] {d_idle, d_addr, d_addr_ack, d_wr, d_wr_ack, d_rd, d_rd_ack}
    dev_state_type;
  typedef enum logic [1:0] {h_idle, h_start, h_bit, h_stop} host_state_type;
  typedef struct packed {
    logic scl_p;
    logic sda_p;
    logic tick_p;
    logic [`NUM_SRC-1:0] lvl_p;
    logic [`PG_CNT_W-1:0] pg_cnt;
    logic [1:0] fault_ticks;
    logic pg;
    logic started;
    logic gate_off;
    logic [7:0] ctrl;
    logic [7:0] mask;
    logic [7:0] src1;
    logic [`NUM_SRC-1:0] pend;
    logic [`ADC_BITS-1:0] adc;
    logic irq_oe;
    dev_state_type st;
    logic [3:0] bitcnt;
    logic [7:0] shift;
    logic [7:0] ptr;
    logic first;
    logic rw;
    logic [7:0] tx;
    logic sda_oe;
  } dev_reg_type;
endpackage

// >>> verification/sup_link_assertions.sv
/*
  Checker for the two-wire link between the host end and the device end.
  Assumes host QUARTER of at least 4, so each clock phase lasts 8 sys_clk or more.
*/
`timescale 1ns/1ns
`include "sup_params.svh"
module sup_link_assertions (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Link
  input wire logic scl_o,
  input wire logic scl_oe,
  input wire logic sda_m_o,
  input wire logic sda_m_oe,
  input wire logic sda_d_o,
  input wire logic sda_d_oe,
  input wire logic scl,
  input wire logic sda
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  typedef struct packed {
    logic scl;
    logic sda;
    logic first;
    logic [3:0] pos;
    logic [7:0] addr;
  } mon_type;
  mon_type m_r;
  mon_type m_nxt;
  logic addr_hit;
  //////////////////////////////////////////////////////////////
  // Bit position since start; a stop also counts one rise, which a_scl_high_hold and, after a write address, a_dev_quiet also check
  always_comb begin
    m_nxt = m_r;
    m_nxt.scl = scl;
    m_nxt.sda = sda;
    if (scl && m_r.scl && m_r.sda && !sda) begin
      m_nxt.pos = 4'h0;
      m_nxt.first = 1'h1;
    end else if (scl && !m_r.scl) begin
      m_nxt.pos = (m_r.pos == 4'h8) ? 4'h0 : m_r.pos + 4'h1;
      if (m_r.pos == 4'h8) m_nxt.first = 1'h0;
      if (m_r.first && m_r.pos != 4'h8) m_nxt.addr = {m_r.addr[6:0], sda};
    end
  end
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) m_r <= '{1'h1, 1'h1, 1'h0, 4'h0, 8'h00};
    else m_r <= m_nxt;
  end
  assign addr_hit = (m_r.addr[7:1] == `I2C_DEV_ADDR);
  //////////////////////////////////////////////////////////////
  a_open_drain: assert property (!(scl_o || sda_m_o || sda_d_o))
    else $error("link driven high");
  a_scl_high_hold: assert property ($rose(scl) |-> scl [*8])
    else $error("scl high phase too short");
  a_scl_low_hold: assert property ($fell(scl) |-> !scl [*8])
    else $error("scl low phase too short");
  a_dev_grab_low: assert property ($rose(sda_d_oe) |-> !scl)
    else $error("device took sda while scl high");
  a_dev_drop_low: assert property ($fell(sda_d_oe) |-> !scl)
    else $error("device freed sda while scl high");
  a_addr_ack_prompt: assert property ($fell(scl) && m_r.pos == 4'h8 && m_r.first && addr_hit
    |-> ##[1:6] sda_d_oe) else $error("address ack late");
  a_addr_ack_held: assert property ($rose(scl) && m_r.pos == 4'h8 && m_r.first && addr_hit
    |-> !sda) else $error("address ack missing");
  a_ack_bit_free: assert property ($rose(scl) && m_r.pos == 4'h8 |-> !sda_m_oe)
    else $error("master held sda in ack slot");
  a_dev_quiet: assert property ($rose(scl) && m_r.pos != 4'h8 && (m_r.first || !m_r.addr[0])
    |-> !sda_d_oe) else $error("device drove a master bit");
  a_read_end_free: assert property ($rose(scl) && m_r.pos == 4'h8 && !m_r.first && m_r.addr[0]
    |-> !sda_d_oe) else $error("device held sda in read ack slot");
endmodule

// >>> verification/tb.sv
/*
  Testbench: host end on AHB-Lite drives the device end across the link.
  Assumes shortened qualification (QUAL) and bit timing (QUARTER 8).
*/
`timescale 1ns/1ns
`include "sup_params.svh"
module tb;
  localparam int QUAL = 50;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp, gate_off, bulk, aux_o, aux_oe, irq_o, irq_oe, pg;
  logic [31:0] hrdata, rd;
  logic tight = 1'b0;
  logic wide = 1'b0;
  logic tick = 1'b0;
  logic [6:0] lv = 7'h00;
  logic [6:0] adc = 7'h00;
  logic [1:0] adc_sel;
  int failures = 0;
  int n_tests = 0;
  int cyc = 0;
  i2c_link_if link ();
  always #10 sys_clk = ~sys_clk;
  //////////////////////////////////////////////////////////////
  sup_device #(.PG_QUAL_CYCLES(QUAL)) sup_device_inst (.sys_clk(sys_clk), .resetn(resetn),
    .link(link.dev), .in_tight_window(tight), .out_wide_window(wide), .switch_cycle_tick(tick),
    .thermal_trip(lv[2]), .enable_low(lv[1]), .excess_output_flag(lv[0]),
    .internal_overcurrent_flag(lv[4]), .overcurrent_indicator_pin(lv[5]),
    .negative_step_flag(lv[6]), .adc_code(adc), .adc_select(adc_sel), .gate_drive_off(gate_off),
    .bulk_cap_switch(bulk), .aux_driver_o(aux_o), .aux_driver_oe(aux_oe), .irq_out_pin_o(irq_o),
    .irq_out_pin_oe(irq_oe), .output_in_window(pg));
  i2c_host_end #(.QUARTER(8)) i2c_host_end_inst (.sys_clk(sys_clk), .resetn(resetn),
    .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hready(hreadyout), .hwdata(hwdata), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .link(link.host));
  sup_link_assertions sup_link_assertions_inst (.sys_clk(sys_clk), .resetn(resetn),
    .scl_o(link.scl_o), .scl_oe(link.scl_oe), .sda_m_o(link.sda_m_o), .sda_m_oe(link.sda_m_oe),
    .sda_d_o(link.sda_d_o), .sda_d_oe(link.sda_d_oe), .scl(link.scl), .sda(link.sda));
  //////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("Checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Every wait goes through here, so one budget bounds all of them
  task automatic step();
    @(posedge sys_clk);
    cyc++;
    if (cyc > 95000) begin
      failures++;
      finish_test();
    end
  endtask
  task automatic idle(input int n);
    repeat (n) step();
  endtask
  task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] d);
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    step();
    while (hreadyout !== 1'b1) step();
    htrans <= 2'h0;
    hwdata <= d;
    step();
    while (hreadyout !== 1'b1) step();
    rd = hrdata;
  endtask
  task automatic dev(input logic [1:0] kind, input logic [7:0] p, input logic [7:0] d);
    ahb(`HOST_CMD, 1'b1, {1'b1, 7'h00, d, p, 6'h00, kind});
    rd = 32'h1;
    while (rd[0] !== 1'b0) ahb(`HOST_STAT, 1'b0, 32'h0);
    check("nack", rd[1], 1'b0);
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    dev(`KIND_WRITE, p, d);
    idle(4);
  endtask
  task automatic nxchk(input string what, input logic [7:0] exp);
    dev(`KIND_READ, 8'h00, 8'h00);
    check(what, rd[15:8], exp);
  endtask
  task automatic rdchk(input string what, input logic [7:0] p, input logic [7:0] exp);
    dev(`KIND_POINT, p, 8'h00);
    nxchk(what, exp);
  endtask
  task automatic pulse();
    tick <= 1'b1;
    idle(4);
    tick <= 1'b0;
    idle(4);
  endtask
  //////////////////////////////////////////////////////////////
  initial begin
    idle(12);
    resetn <= 1'b1;
    idle(6);
    check("irq_oe", irq_oe, 1'b0);
    check("bulk", bulk, 1'b0);
    check("aux_oe", aux_oe, 1'b0);
    check("pg", pg, 1'b0);
    check("drive_low", {hresp, aux_o, irq_o}, 3'h0);
    rdchk("mask", `REG_MASK, `MASK_RESET);
    nxchk("adc", 8'h00);
    $display("Test reset done");
    for (int s = 0; s < 4; s++) begin
      adc <= 7'h7f >> s;
      wr(`REG_CTRL, {4'h0, s[1:0], s[0], ~s[0]});
      check("sel", adc_sel, s[1:0]);
      check("bulk", bulk, !s[0]);
      check("aux_oe", aux_oe, s[0]);
      rdchk("adc", `REG_ADC, {1'b0, 7'h7f >> s});
    end
    wr(`REG_MASK, 8'h00);
    nxchk("adc_next", 8'h0f);
    $display("Test control done");
    tight <= 1'b1;
    idle(QUAL - 10);
    check("pg_early", pg, 1'b0);
    check("irq_hold", irq_oe, 1'b0);
    idle(20);
    check("pg", pg, 1'b1);
    check("irq_quiet", irq_oe, 1'b1);
    wr(`REG_CTRL, 8'h10);
    check("irq_show", irq_oe, 1'b0);
    wr(`REG_MASK, 8'h08);
    check("irq_pgmask", irq_oe, 1'b1);
    wr(`REG_MASK, 8'h00);
    wr(`REG_CTRL, 8'h00);
    $display("Test power good done");
    tight <= 1'b0;
    wide <= 1'b1;
    idle(4);
    pulse();
    check("pg_one", pg, 1'b1);
    pulse();
    idle(4);
    check("pg_two", pg, 1'b0);
    check("irq_pg", irq_oe, 1'b0);
    // Sources latch only while masked, so mask first and then read
    wr(`REG_MASK, 8'h08);
    check("irq_mask", irq_oe, 1'b1);
    // Requalify so the trip level is gone; the latched bit must outlive it
    tight <= 1'b1;
    wide <= 1'b0;
    idle(QUAL + 10);
    rdchk("src_pg", `REG_SRC1, 8'h08);
    nxchk("status", 8'h03);
    wr(`REG_MASK, 8'h00);
    $display("Test fault window done");
    for (int i = 0; i < 7; i++) begin
      if (i == 3) continue;
      lv[i] <= 1'b1;
      idle(8);
      check("irq_src", irq_oe, 1'b0);
      check("gate_off", gate_off, i == 2);
      wr(`REG_MASK, 8'h01 << i);
      check("irq_mask", irq_oe, 1'b1);
      // Fault gone before the read, so the read clears the latch for good
      lv[i] <= 1'b0;
      rdchk("src", `REG_SRC1, 8'h01 << i);
      wr(`REG_MASK, 8'h00);
    end
    check("scl_idle", link.scl, 1'b1);
    check("sda_idle", link.sda, 1'b1);
    $display("Test sources done");
    finish_test();
  end
endmodule
